//--- src/dfc_seq.sv
// What this block does
// - Clock period stays fixed except inside the two change states.
// - Clock switch requested only in self-refresh or precharge power-down.
// - After self-refresh entry and tCKSRE, clock may change.
// - New clock stable for tCKSRX before self-refresh exit.
// - Self-refresh entry and exit timing still met for frequency changes.
// - New frequency chosen within speed grade limits; FSEL is used as written with no range check, so software must pick it.
// - ODT held low through power-down when nominal termination was on.
// - Power-down change waits tCKSRE after CKE low.
// - ODT and CKE held steady low while frequency changes.
// - New clock stable for tCKSRX before power-down exit.
// - After exit and tXP, reset DLL by mode register set.
// - Extra mode register writes update WR, CL, CWL with CKE high.
// - During DLL re-lock ODT stays low and CKE high.
// - DLL reset sets address bit A8 in mode register 0 write.
// - Wait tDLLK after DLL reset before commands needing lock.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
module dfc_seq
    import dfc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire dfc_bus_t busReq,
    output logic [DW-1:0] rdata,
    input wire logic clkAck,
    output logic clkReq,
    output logic [FW-1:0] freqSel,
    output dfc_pins_t dram,
    output logic busy
);

    typedef struct packed {
        dfc_state_t state;
        logic [CW-1:0] cnt;
        logic cke;
        logic odt;
        dfc_cmd_t cmd;
        logic clkReq;
        logic [FW-1:0] fselOut;
        logic done;
        logic modePd;
        logic upd;
        logic odtIdle;
        logic [CW-1:0] tCksre;
        logic [CW-1:0] tCksrx;
        logic [CW-1:0] tExit;
        logic [CW-1:0] tMrd;
        logic [CW-1:0] tDllk;
        logic [CW-1:0] mr0;
        logic [CW-1:0] mr2;
        logic [FW-1:0] fsel;
        logic [DW-1:0] rdata;
    } dfc_regs_t;

    dfc_regs_t r_q;
    dfc_regs_t r_d;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic dfc_cmd_t mkCmd(
        input logic [3:0] code,
        input logic [2:0] ba,
        input logic [15:0] addr
    );
        dfc_cmd_t c;
        c.csN = code[3];
        c.rasN = code[2];
        c.casN = code[1];
        c.weN = code[0];
        c.ba = ba;
        c.addr = addr;
        return c;
    endfunction : mkCmd

    // Timing and mode registers read back zero-extended
    function automatic logic [DW-1:0] zext(input logic [CW-1:0] v);
        return {{(DW-CW){1'b0}}, v};
    endfunction : zext

    logic busyNow;
    assign busyNow = (r_q.state != S_IDLE);

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        r_d = r_q;
        r_d.cmd = mkCmd(CMD_NOP, 3'h0, 16'h0000);
        r_d.rdata = '0;
        if (r_q.cnt != '0)
        begin
            r_d.cnt = r_q.cnt - CW'(1);
        end

        // ****************************************
        // Register bus
        // ****************************************
        // Register writes; settings stay frozen while a change runs
        // A write while busy is dropped, not queued; software polls STAT
        if (busReq.wr && !busyNow)
        begin
            unique case (busReq.addr)
                OFS_CTRL:
                begin
                    r_d.modePd = busReq.wdata[CTRL_MODE];
                    r_d.upd = busReq.wdata[CTRL_UPD];
                    r_d.odtIdle = busReq.wdata[CTRL_ODT];
                    r_d.odt = busReq.wdata[CTRL_ODT];
                    if (busReq.wdata[CTRL_START])
                    begin
                        r_d.done = 1'b0;
                        r_d.state = S_ENTER;
                    end
                end
                OFS_TCKSRE: r_d.tCksre = busReq.wdata[CW-1:0];
                OFS_TCKSRX: r_d.tCksrx = busReq.wdata[CW-1:0];
                OFS_TEXIT: r_d.tExit = busReq.wdata[CW-1:0];
                OFS_TMRD: r_d.tMrd = busReq.wdata[CW-1:0];
                OFS_TDLLK: r_d.tDllk = busReq.wdata[CW-1:0];
                OFS_MR0: r_d.mr0 = busReq.wdata[CW-1:0];
                OFS_MR2: r_d.mr2 = busReq.wdata[CW-1:0];
                // Software must pick a rate inside the speed grade
                OFS_FSEL: r_d.fsel = busReq.wdata[FW-1:0];
                default: ;
            endcase
        end

        if (busReq.rd)
        begin
            unique case (busReq.addr)
                OFS_CTRL:
                begin
                    // START is a strobe and always reads back as zero
                    r_d.rdata[CTRL_MODE] = r_q.modePd;
                    r_d.rdata[CTRL_UPD] = r_q.upd;
                    r_d.rdata[CTRL_ODT] = r_q.odtIdle;
                end
                OFS_STAT:
                begin
                    r_d.rdata[STAT_BUSY] = busyNow;
                    r_d.rdata[STAT_DONE] = r_q.done;
                    r_d.rdata[STAT_STATE +: 4] = r_q.state;
                end
                OFS_TCKSRE: r_d.rdata = zext(r_q.tCksre);
                OFS_TCKSRX: r_d.rdata = zext(r_q.tCksrx);
                OFS_TEXIT: r_d.rdata = zext(r_q.tExit);
                OFS_TMRD: r_d.rdata = zext(r_q.tMrd);
                OFS_TDLLK: r_d.rdata = zext(r_q.tDllk);
                OFS_MR0: r_d.rdata = zext(r_q.mr0);
                OFS_MR2: r_d.rdata = zext(r_q.mr2);
                OFS_FSEL: r_d.rdata = DW'(r_q.fsel);
                default: r_d.rdata = '0;
            endcase
        end

        // ****************************************
        // Sequencer
        // ****************************************
        // The clock may only move while CKE is low; each timed wait except S_WMRD2 counts cnt down to zero
        unique case (r_q.state)
            S_IDLE: ;
            S_ENTER:
            begin
                // ODT low from entry on keeps termination off in power-down
                r_d.odt = 1'b0;
                r_d.cke = 1'b0;
                if (!r_q.modePd)
                begin
                    r_d.cmd = mkCmd(CMD_REF, 3'h0, 16'h0000);
                end
                r_d.cnt = r_q.tCksre;
                r_d.state = S_WSRE;
            end
            S_WSRE:
            begin
                if (r_q.cnt == '0)
                begin
                    r_d.state = S_SWITCH;
                end
            end
            S_SWITCH:
            begin
                // Only reachable with CKE low, so the clock is don't care
                r_d.clkReq = 1'b1;
                r_d.fselOut = r_q.fsel;
                if (r_q.clkReq && clkAck)
                begin
                    r_d.clkReq = 1'b0;
                    r_d.cnt = r_q.tCksrx;
                    r_d.state = S_WSRX;
                end
            end
            S_WSRX:
            begin
                // Margin after the ack, which only says the source has settled
                if (r_q.cnt == '0)
                begin
                    r_d.state = S_EXIT;
                end
            end
            S_EXIT:
            begin
                // Self-refresh exit is a NOP with CKE rising
                r_d.cke = 1'b1;
                r_d.cnt = r_q.tExit;
                r_d.state = S_WEXIT;
            end
            S_WEXIT:
            begin
                // One register serves tXS after self-refresh and tXP after power-down
                if (r_q.cnt == '0)
                begin
                    r_d.state = S_DLLRST;
                end
            end
            S_DLLRST:
            begin
                // New WR and CL ride on the same write as the DLL reset
                r_d.cmd = mkCmd(CMD_MRS, BA_MR0,
                    r_q.mr0 | (CW'(1) << MR0_DLL_RST));
                r_d.cnt = r_q.tMrd;
                r_d.state = S_WMRD;
            end
            S_WMRD:
            begin
                if (r_q.cnt == '0)
                begin
                    r_d.state = r_q.upd ? S_MR2 : S_LOCK;
                    // Lock time counted from the reset, less time spent here
                    r_d.cnt = (r_q.tDllk > r_q.tMrd) ? r_q.tDllk - r_q.tMrd : '0;
                end
            end
            S_MR2:
            begin
                // Keep the longer of the lock remainder and the tMRD gap
                r_d.cmd = mkCmd(CMD_MRS, BA_MR2, r_q.mr2);
                r_d.cnt = (r_q.cnt > r_q.tMrd) ? r_q.cnt : r_q.tMrd;
                r_d.state = S_WMRD2;
            end
            S_WMRD2:
            begin
                // One spare cycle; the lock count keeps running meanwhile
                r_d.state = S_LOCK;
            end
            S_LOCK:
            begin
                // CKE high and ODT low without a break until lock
                if (r_q.cnt == '0)
                begin
                    r_d.odt = r_q.odtIdle;
                    r_d.done = 1'b1;
                    r_d.state = S_IDLE;
                end
            end
            default: r_d.state = S_IDLE;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            r_q <= '0;
            r_q.state <= S_IDLE;
            r_q.cke <= 1'b1;
            r_q.cmd <= mkCmd(CMD_NOP, 3'h0, 16'h0000);
            r_q.fselOut <= DEF_FSEL;
            // Timing defaults return on reset so a bare start keeps safe spacing
            r_q.tCksre <= DEF_TCKSRE;
            r_q.tCksrx <= DEF_TCKSRX;
            r_q.tExit <= DEF_TEXIT;
            r_q.tMrd <= DEF_TMRD;
            r_q.tDllk <= DEF_TDLLK;
            r_q.mr0 <= DEF_MR0;
            r_q.mr2 <= DEF_MR2;
            r_q.fsel <= DEF_FSEL;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // All pins come straight from flip-flops; only busy is decoded
    assign rdata = r_q.rdata;
    assign clkReq = r_q.clkReq;
    assign freqSel = r_q.fselOut;
    assign dram.cke = r_q.cke;
    assign dram.odt = r_q.odt;
    assign dram.cmd = r_q.cmd;
    assign busy = busyNow;

endmodule : dfc_seq

//--- shared/dfc_pkg.sv
// ****************************************
// Clock frequency change sequencer package
// ****************************************
package dfc_pkg;

    localparam int AW = 6;
    localparam int DW = 32;
    localparam int CW = 16;
    localparam int FW = 4;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [AW-1:0] OFS_CTRL = 6'h00;
    localparam logic [AW-1:0] OFS_STAT = 6'h04;
    localparam logic [AW-1:0] OFS_TCKSRE = 6'h08;
    localparam logic [AW-1:0] OFS_TCKSRX = 6'h0C;
    localparam logic [AW-1:0] OFS_TEXIT = 6'h10;
    localparam logic [AW-1:0] OFS_TMRD = 6'h14;
    localparam logic [AW-1:0] OFS_TDLLK = 6'h18;
    localparam logic [AW-1:0] OFS_MR0 = 6'h1C;
    localparam logic [AW-1:0] OFS_MR2 = 6'h20;
    localparam logic [AW-1:0] OFS_FSEL = 6'h24;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_UPD = 2;
    localparam int CTRL_ODT = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_STATE = 8;
    localparam int MR0_DLL_RST = 8;

    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR2 = 3'h2;

    // csN rasN casN weN
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;

    // ****************************************
    // Timing defaults, reprogrammable
    // ****************************************
    localparam int CLK_NS = 50;
    localparam int T_CKSRE_NS = 10;
    localparam int T_CKSRX_NS = 10;
    localparam int T_EXIT_NS = 170;
    localparam int T_MRD_NCK = 4;
    localparam int T_DLLK_NCK = 512;
    localparam logic [CW-1:0] DEF_TCKSRE = CW'((T_CKSRE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] DEF_TCKSRX = CW'((T_CKSRX_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] DEF_TEXIT = CW'((T_EXIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CW-1:0] DEF_TMRD = CW'(T_MRD_NCK);
    localparam logic [CW-1:0] DEF_TDLLK = CW'(T_DLLK_NCK);
    localparam logic [CW-1:0] DEF_MR0 = 16'h0000;
    localparam logic [CW-1:0] DEF_MR2 = 16'h0000;
    localparam logic [FW-1:0] DEF_FSEL = 4'h0;

    typedef enum logic [3:0] {
        S_IDLE, S_ENTER, S_WSRE, S_SWITCH, S_WSRX, S_EXIT,
        S_WEXIT, S_DLLRST, S_WMRD, S_MR2, S_WMRD2, S_LOCK
    } dfc_state_t;

    typedef struct packed {
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
        logic [2:0] ba;
        logic [15:0] addr;
    } dfc_cmd_t;

    typedef struct packed {
        logic cke;
        logic odt;
        dfc_cmd_t cmd;
    } dfc_pins_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } dfc_bus_t;

endpackage : dfc_pkg

//--- tb/dfc_seq_properties.sv
`timescale 1ns/1ps
// ****************************************
// Pin sequencing checks
// ****************************************
module dfc_seq_properties
    import dfc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkAck,
    input wire logic clkReq,
    input wire logic [FW-1:0] freqSel,
    input wire dfc_pins_t dram,
    input wire logic busy
);
    logic [3:0] code;
    logic mr0;
    assign code = {dram.cmd.csN, dram.cmd.rasN, dram.cmd.casN, dram.cmd.weN};
    assign mr0 = code == CMD_MRS && dram.cmd.ba == BA_MR0;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    switch_pins_low_a: assert property (clkReq |-> !dram.cke && !dram.odt)
        else $error("cke or odt high during clock switch");
    switch_after_entry_a: assert property ($rose(clkReq) |-> !$past(dram.cke))
        else $error("clock switch without prior cke low");
    freq_hold_a: assert property (clkReq && $past(clkReq) |-> $stable(freqSel))
        else $error("frequency select moved during switch");
    ack_exit_a: assert property (clkReq && clkAck |=> !clkReq && !dram.cke ##1 !dram.cke)
        else $error("exit too soon after new clock");
    exit_nop_a: assert property ($rose(dram.cke) |-> (code == CMD_NOP) [*4])
        else $error("command too soon after exit");
    odt_low_busy_a: assert property (busy && $past(busy) |-> !dram.odt)
        else $error("odt high during sequence");
    mrs_pins_a: assert property (code == CMD_MRS |-> dram.cke && !dram.odt)
        else $error("mode write without cke high and odt low");
    dll_reset_bit_a: assert property (mr0 |-> dram.cmd.addr[MR0_DLL_RST])
        else $error("mode register 0 write without dll reset");
    lock_wait_a: assert property (mr0 |=> busy [*4])
        else $error("sequence ended too soon after dll reset");
    cover property (code == CMD_REF);
    cover property (code == CMD_MRS && dram.cmd.ba == BA_MR2);
    cover property ($fell(busy));
endmodule : dfc_seq_properties

bind dfc_seq dfc_seq_properties u_props (.clk, .nrst, .clkAck, .clkReq, .freqSel, .dram, .busy);

//--- tb/dfc_dram_model.sv
`timescale 1ns/1ps
// ****************************************
// Memory and clock source model
// ****************************************
module dfc_dram_model
    import dfc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkReq,
    input wire logic [3:0] lag,
    input wire dfc_pins_t dram,
    output logic clkAck,
    output logic bad,
    output logic locked
);
    logic [3:0] ackCnt;
    logic [4:0] lockCnt;
    // A slow source holds off the answer until its output has settled
    assign clkAck = clkReq && ackCnt >= lag;
    assign locked = lockCnt == 5'h00;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ackCnt <= 4'h0;
            lockCnt <= 5'h00;
            bad <= 1'b0;
        end
        else
        begin
            ackCnt <= clkReq ? ackCnt + 4'h1 : 4'h0;
            // Clock is only a don't care with cke low; odt is held low too
            if (clkReq && (dram.cke || dram.odt))
                bad <= 1'b1;
            if (!dram.cmd.csN && !dram.cmd.rasN && dram.cmd.ba == BA_MR0 &&
                dram.cmd.addr[MR0_DLL_RST])
                lockCnt <= 5'h08;
            else if (lockCnt != 5'h00)
                lockCnt <= lockCnt - 5'h01;
        end
    end
endmodule : dfc_dram_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import dfc_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] lag = 4'h0;
    logic clkReq, clkAck, busy, bad, locked;
    logic [DW-1:0] rdata;
    logic [FW-1:0] freqSel;
    logic [15:0] mr0Seen;
    logic [3:0] code;
    dfc_bus_t bus = '0;
    dfc_pins_t dram;
    int errors = 0;
    int n_tests = 0;
    int nRef, nMr2;
    always #25 clk = ~clk;
    assign code = {dram.cmd.csN, dram.cmd.rasN, dram.cmd.casN, dram.cmd.weN};
    dfc_seq u_dut (.clk(clk), .nrst(nrst), .busReq(bus), .rdata(rdata), .clkAck(clkAck),
        .clkReq(clkReq), .freqSel(freqSel), .dram(dram), .busy(busy));
    dfc_dram_model u_mem (.clk(clk), .nrst(nrst), .clkReq(clkReq), .lag(lag), .dram(dram),
        .clkAck(clkAck), .bad(bad), .locked(locked));
    // ****************************************
    // Access tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    task rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge clk);
        bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        bus <= '0;
        #1;
        check(rdata, exp);
    endtask : rd
    task final_report;
        $display("errors %0d of %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    always @(posedge clk)
    begin
        if (code == CMD_REF)
            nRef++;
        if (code == CMD_MRS && dram.cmd.ba == BA_MR2)
            nMr2++;
        if (code == CMD_MRS && dram.cmd.ba == BA_MR0)
            mr0Seen = dram.cmd.addr;
    end
    // Mode 0: self-refresh, prompt clock; mode 1: power-down, slow clock, MR2 update
    task run(input logic m);
        nRef = 0;
        nMr2 = 0;
        mr0Seen = 16'h0000;
        lag <= m ? 4'h3 : 4'h0;
        wr(OFS_FSEL, 32'h5 + 32'(m));
        wr(OFS_CTRL, {28'h0, m, m, m, 1'b1});
        wr(OFS_TCKSRX, 32'h7);
        wr(OFS_CTRL, 32'h1);
        repeat (300)
        begin
            @(posedge clk);
            #1;
            if (busy === 1'b0)
                break;
        end
        check(32'(locked), 32'h1);
        check(32'(nRef), m ? 32'h0 : 32'h1);
        check(32'(mr0Seen), 32'h0110);
        check(32'(nMr2), 32'(m));
        check(32'(freqSel), 32'h5 + 32'(m));
        check(32'({dram.cke, dram.odt}), {30'h0, 1'b1, m});
        rd(OFS_STAT, 32'h2);
        rd(OFS_TCKSRX, 32'h2);
        repeat (10) @(posedge clk);
        #1;
        check(32'({bad, busy, locked}), 32'h1);
    endtask : run
    initial
    begin
        #200000;
        errors++;
        final_report;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        check(32'({dram.cke, dram.odt, clkReq, busy}), 32'h8);
        @(posedge clk);
        nrst <= 1'b1;
        rd(OFS_STAT, 32'h0);
        rd(OFS_TEXIT, 32'(DEF_TEXIT));
        rd(OFS_TDLLK, 32'(DEF_TDLLK));
        wr(OFS_TDLLK, 32'h8);
        wr(OFS_TCKSRX, 32'h2);
        wr(OFS_MR0, 32'h10);
        wr(OFS_MR2, 32'h18);
        wr(6'h3C, 32'hFF);
        rd(6'h3C, 32'h0);
        rd(OFS_TDLLK, 32'h8);
        run(1'b0);
        run(1'b1);
        final_report;
    end
endmodule : testbench
